// ==== logic/ppmhp_regs.svh ====
`ifndef PPMHP_REGS_SVH
`define PPMHP_REGS_SVH

// ----------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------
`define PPMHP_ADDR_W       9
`define PPMHP_DATA_W       8
`define PPMHP_REG_DEPTH    512

// ----------------------------------------------------------------
// Register defaults and pin control offsets
// ----------------------------------------------------------------
`define PPMHP_REG_RESET    8'h00
`define PPMHP_PIN_DIR_ADDR 9'h018
`define PPMHP_PIN_OUT_ADDR 9'h019

// ----------------------------------------------------------------
// Strap defaults, as the pins read when left open
// ----------------------------------------------------------------
`define PPMHP_STRAP_BUS_DEF  1'b1
`define PPMHP_STRAP_SYNC_DEF 1'b1
`define PPMHP_STRAP_CLK_DEF  1'b0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PPMHP_MCLK_PERIOD_NS 40
`define PPMHP_RST_HOLD_CYC   2

`endif

// ==== logic/ppmhp_pkg.sv ====
`include "ppmhp_regs.svh"

package ppmhp_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [`PPMHP_ADDR_W-1:0] ppmhp_addr_t;
  typedef logic [`PPMHP_DATA_W-1:0] ppmhp_data_t;

  // Access tracker, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_READ  = 3'h2,
    ST_WRITE = 3'h4
  } ppmhp_state_e;

  // Host bus inputs, sampled on mclk
  typedef struct packed {
    logic        chip_select_n;
    logic        address_strobe_n;
    logic        data_strobe_n;
    logic        dir_strobe_n;
    ppmhp_addr_t addr;
    ppmhp_data_t ad_in;
  } ppmhp_bus_s;

endpackage

// ==== logic/ppmhp_sync2.sv ====
`timescale 1ns/1ps

module ppmhp_sync2 import ppmhp_pkg::*; (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Level in and out
  input  wire logic d,
  output logic      q
);

  logic [1:0] sync_q;
  logic [1:0] sync_d;

  // Two-stage shift; only the second stage leaves the module
  always_comb begin
    sync_d = {sync_q[0], d};
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= 2'h0;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign q = sync_q[1];

endmodule // ppmhp_sync2

// ==== logic/ppmhp_regfile.sv ====
`timescale 1ns/1ps
`include "ppmhp_regs.svh"

module ppmhp_regfile import ppmhp_pkg::*; (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Write port
  input  wire logic         we,
  input  wire ppmhp_addr_t  waddr,
  input  wire ppmhp_data_t  wdata,
  // Read port
  input  wire ppmhp_addr_t  raddr,
  output ppmhp_data_t       rdata_q,
  // Pin control taps
  output ppmhp_data_t       pin_dir,
  output ppmhp_data_t       pin_val
);

  ppmhp_data_t ent_q [`PPMHP_REG_DEPTH];
  ppmhp_data_t ent_d [`PPMHP_REG_DEPTH];
  ppmhp_data_t rdata_d;

  // ----------------------------------------------------------------
  // Register entries, each back to default under reset
  // ----------------------------------------------------------------
  for (genvar i = 0; i < `PPMHP_REG_DEPTH; i++) begin : g_ent
    always_comb begin
      ent_d[i] = (we && waddr == ppmhp_addr_t'(i)) ? wdata : ent_q[i];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        ent_q[i] <= `PPMHP_REG_RESET;
      end else begin
        ent_q[i] <= ent_d[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered read data
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = ent_q[raddr];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `PPMHP_REG_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign pin_dir = ent_q[`PPMHP_PIN_DIR_ADDR];
  assign pin_val = ent_q[`PPMHP_PIN_OUT_ADDR];

endmodule // ppmhp_regfile

// ==== logic/ppmhp_port.sv ====
`timescale 1ns/1ps
`include "ppmhp_regs.svh"

// Contract
// - Reset release leaves every register at its default value.
// - Reset release leaves every programmable pin as an input.
// - Power-on reset does the same as the reset pin.
// - Clock-source strap low: internal timing, external clock ignored.
// - External clock sets register update and strobe sampling rate.
// - Bus style 0: separate address, one data strobe, direction bit.
// - Bus style 1: muxed bus, top address line, read/write strobes.
// - Async mode: strobes steer enable and latch; write synchronised.
// - Sync mode needs external clock; strobes sampled on rising edge.
// - Sync mode finishes cycles with zero wait states.
// - Address strobe falling edge latches the register address.
// - Latched nine-bit address picks exactly one register.
// - Select low enables decode; select high ends access, floats bus.
// - Open straps default to muxed, synchronous; reset inactive.
// - Sync separate-bus mode drives acknowledge while strobe, select low.

module ppmhp_port import ppmhp_pkg::*; (
  // Clock and resets
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        por_n,
  // Mode straps
  input  wire logic        bus_style_select,
  input  wire logic        sync_bus_select,
  input  wire logic        clock_source_select,
  // Host bus
  input  wire ppmhp_bus_s  host,
  output ppmhp_data_t      ad_out,
  output logic             ad_oe,
  output logic             transfer_ack_n_out,
  output logic             transfer_ack_n_oe,
  // Programmable pins
  output ppmhp_data_t      programmable_io_pins_out,
  output ppmhp_data_t      programmable_io_pins_oe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic         rst_n;
  logic         first_q, first_d;
  logic         bus_style_q, bus_style_d;
  logic         sync_sel_q, sync_sel_d;
  logic         clk_src_q, clk_src_d;
  logic         eff_sync;
  logic         sep_bus;
  logic         as_prev_q, as_prev_d;
  logic         as_fall;
  ppmhp_addr_t  addr_in;
  ppmhp_addr_t  addr_cur;
  ppmhp_addr_t  addr_q, addr_d;
  logic         sel;
  logic         sync_go;
  logic         rd_act;
  logic         wr_act;
  ppmhp_state_e state_q, state_d;
  logic         wr_evt;
  logic         wlat_open;
  ppmhp_data_t  wdata_q, wdata_d;
  ppmhp_addr_t  waddr_q, waddr_d;
  logic         wr_pend_q, wr_pend_d;
  logic         wr_async;
  logic         mem_we;
  ppmhp_data_t  rdata_q;
  ppmhp_data_t  pin_dir;
  ppmhp_data_t  pin_val;

  // ----------------------------------------------------------------
  // Reset sources
  // ----------------------------------------------------------------
  // Pin and power-on reset share one path; held eight edges by the host
  assign rst_n = reset_n & por_n;

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Straps taken on the first edge after release; open pins read high, except clock source, which reads low
  always_comb begin
    first_d     = 1'b0;
    bus_style_d = first_q ? bus_style_select    : bus_style_q;
    sync_sel_d  = first_q ? sync_bus_select     : sync_sel_q;
    clk_src_d   = first_q ? clock_source_select : clk_src_q;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      first_q     <= 1'b1;
      bus_style_q <= `PPMHP_STRAP_BUS_DEF;
      sync_sel_q  <= `PPMHP_STRAP_SYNC_DEF;
      clk_src_q   <= `PPMHP_STRAP_CLK_DEF;
    end else begin
      first_q     <= first_d;
      bus_style_q <= bus_style_d;
      sync_sel_q  <= sync_sel_d;
      clk_src_q   <= clk_src_d;
    end
  end

  // Sync timing only counts with the external clock selected
  assign eff_sync = sync_sel_q & clk_src_q;
  assign sep_bus  = ~bus_style_q;

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  assign sel     = ~host.chip_select_n;
  assign sync_go = sel & ~host.address_strobe_n;

  // Separate bus: strobe plus direction; muxed bus: two strobes
  always_comb begin
    if (sep_bus) begin
      rd_act = ~host.data_strobe_n & host.dir_strobe_n;
      wr_act = ~host.data_strobe_n & ~host.dir_strobe_n;
    end else begin
      rd_act = ~host.data_strobe_n;
      wr_act = ~host.dir_strobe_n;
    end
  end

  // ----------------------------------------------------------------
  // Address latch
  // ----------------------------------------------------------------
  // Muxed bus keeps only the top address line
  assign addr_in = sep_bus ? host.addr
                           : {host.addr[8], host.ad_in};
  assign as_fall  = as_prev_q & ~host.address_strobe_n;
  assign addr_cur = as_fall ? addr_in : addr_q;

  always_comb begin
    as_prev_d = host.address_strobe_n;
    addr_d    = addr_cur;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      as_prev_q <= 1'b1;
      addr_q    <= '0;
    end else begin
      as_prev_q <= as_prev_d;
      addr_q    <= addr_d;
    end
  end

  // ----------------------------------------------------------------
  // Access tracker
  // ----------------------------------------------------------------
  // Inputs sampled every rising mclk edge in either timing mode
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (eff_sync) begin
          if (sync_go && rd_act) begin
            state_d = ST_READ;
          end else if (sync_go && wr_act) begin
            state_d = ST_WRITE;
          end
        end else begin
          if (sel && rd_act) begin
            state_d = ST_READ;
          end else if (sel && wr_act) begin
            state_d = ST_WRITE;
          end
        end
      end
      ST_READ: begin
        if (!sel || !rd_act) begin
          state_d = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (!sel || !wr_act) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  // Sync: write taken at strobe start; async: at strobe release
  assign wr_evt = eff_sync
                ? (state_q == ST_IDLE  && state_d == ST_WRITE)
                : (state_q == ST_WRITE && state_d == ST_IDLE);
  // Async data latch is transparent while the write strobe is low
  assign wlat_open = eff_sync ? wr_evt : (sel & wr_act);

  always_comb begin
    wdata_d   = wlat_open ? host.ad_in : wdata_q;
    waddr_d   = wr_evt ? addr_cur : waddr_q;
    wr_pend_d = wr_evt;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wdata_q   <= '0;
      waddr_q   <= '0;
      wr_pend_q <= 1'b0;
    end else begin
      wdata_q   <= wdata_d;
      waddr_q   <= waddr_d;
      wr_pend_q <= wr_pend_d;
    end
  end

  // Async writes cross two stages before reaching the register
  ppmhp_sync2 i_ppmhp_sync2 (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (wr_pend_q),
    .q     (wr_async)
  );

  assign mem_we = eff_sync ? wr_pend_q : wr_async;

  // ----------------------------------------------------------------
  // Register store
  // ----------------------------------------------------------------
  ppmhp_regfile i_ppmhp_regfile (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .we      (mem_we),
    .waddr   (waddr_q),
    .wdata   (wdata_q),
    .raddr   (addr_cur),
    .rdata_q (rdata_q),
    .pin_dir (pin_dir),
    .pin_val (pin_val)
  );

  // ----------------------------------------------------------------
  // Bus drivers
  // ----------------------------------------------------------------
  // Read data floats as soon as select or read qualifier drops
  assign ad_out = rdata_q;
  assign ad_oe  = sel & rd_act
                & (eff_sync ? (state_q == ST_READ) : 1'b1);

  // Acknowledge only in sync separate-bus mode, open drain
  assign transfer_ack_n_out = 1'b0;
  assign transfer_ack_n_oe  = eff_sync & sep_bus & sync_go;

  // Pin direction defaults to input after any reset
  assign programmable_io_pins_out = pin_val;
  assign programmable_io_pins_oe  = pin_dir;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_sync_wr_begin;
    eff_sync && wr_evt;
  endsequence

  sequence s_async_wr_begin;
    !eff_sync && wr_evt;
  endsequence

  AST_ACK_DRIVE: assert property (@(posedge mclk) disable iff (!rst_n)
    (eff_sync && sep_bus && sel && !host.address_strobe_n)
      |-> (transfer_ack_n_oe && !transfer_ack_n_out))
    else $error("ack not driven during sync access");

  AST_ACK_QUIET: assert property (@(posedge mclk) disable iff (!rst_n)
    (!eff_sync || !sep_bus || host.chip_select_n || host.address_strobe_n)
      |-> !transfer_ack_n_oe)
    else $error("ack driven outside sync separate-bus access");

  AST_CS_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
    host.chip_select_n |-> (!ad_oe ##1 state_q == ST_IDLE))
    else $error("select high did not end access");

  AST_READ_QUAL: assert property (@(posedge mclk) disable iff (!rst_n)
    ad_oe |-> (!host.chip_select_n && !host.data_strobe_n
               && (!sep_bus || host.dir_strobe_n) && ad_out == rdata_q))
    else $error("data driven without read qualifier");

  AST_SYNC_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
    s_sync_wr_begin |-> ##1 (mem_we && waddr_q == $past(addr_cur)
                             && wdata_q == $past(host.ad_in)))
    else $error("sync write not committed next cycle");

  AST_ASYNC_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
    s_async_wr_begin |-> (!mem_we [*1] ##1 !mem_we ##1 !mem_we ##1 mem_we))
    else $error("async write not committed after crossing");

  AST_ADDR_LATCH: assert property (@(posedge mclk) disable iff (!rst_n)
    as_fall |=> (addr_q == $past(addr_in)))
    else $error("address not latched on strobe fall");

  AST_RESET_PINS: assert property (@(posedge mclk) disable iff (!rst_n)
    first_q |-> (programmable_io_pins_oe == 8'h00 && rdata_q == 8'h00))
    else $error("pins or data not at default after reset");

  AST_INT_CLOCK: assert property (@(posedge mclk) disable iff (!rst_n)
    (!clk_src_q && !first_q) |-> (!transfer_ack_n_oe && !eff_sync))
    else $error("sync timing active on internal clock");

  AST_SYNC_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    (eff_sync && state_q == ST_IDLE && sync_go && rd_act)
      ##1 (sel && rd_act) |-> ad_oe)
    else $error("sync read not driven after sampled edge");

endmodule // ppmhp_port

// ==== testbench/ppmhp_host_model.sv ====
`timescale 1ns/1ps

module ppmhp_host_model import ppmhp_pkg::*; (
  // Clock
  input  wire logic        mclk,
  // Device side of the bus
  input  wire ppmhp_data_t ad_out,
  input  wire logic        ad_oe,
  input  wire logic        ack_oe,
  // Host bus
  output ppmhp_bus_s       host
);
  // ----------------------------------------------------------------
  // Bus wire
  // ----------------------------------------------------------------
  ppmhp_bus_s drv    = {4'hF, 17'h00000};
  logic       drv_oe = 1'b1;

  // Host, else device, else the inverse of the last host byte
  always_comb begin
    host       = drv;
    host.ad_in = drv_oe ? drv.ad_in : (ad_oe ? ad_out : ~drv.ad_in);
  end

  // ----------------------------------------------------------------
  // Access cycle
  // ----------------------------------------------------------------
  // Address phase, then select with strobes held to the sample point
  task automatic access(input logic muxed, input logic wr,
                        input ppmhp_addr_t a, input ppmhp_data_t d,
                        output ppmhp_data_t rd, output logic oe,
                        output logic ack, output logic oe_off);
    @(negedge mclk);
    drv.address_strobe_n = 1'b0;
    drv.addr             = muxed ? {a[8], ~a[7:0]} : a;
    drv.ad_in            = muxed ? a[7:0] : d;
    @(negedge mclk);
    drv.chip_select_n    = 1'b0;
    drv.ad_in            = d;
    drv_oe               = wr;
    drv.data_strobe_n    = muxed & wr;
    drv.dir_strobe_n     = ~wr;
    @(negedge mclk);
    rd  = host.ad_in;
    oe  = ad_oe;
    ack = ack_oe;
    @(negedge mclk);
    drv    = {4'hF, 9'h000, drv.ad_in};
    drv_oe = 1'b1;
    #1 oe_off = ad_oe;
    // Gap covers the write hand-over into the register
    repeat (4) @(posedge mclk);
  endtask
endmodule // ppmhp_host_model

// ==== testbench/parallel_mpu_host_port_tb.sv ====
`timescale 1ns/1ps

module parallel_mpu_host_port_tb;
  import ppmhp_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk     = 1'b0;
  logic        reset_n  = 1'b0;
  logic        por_n    = 1'b0;
  logic        bus_sel  = 1'b1;
  logic        sync_sel = 1'b1;
  logic        clk_sel  = 1'b0;
  ppmhp_bus_s  host;
  ppmhp_data_t ad_out;
  ppmhp_data_t pin_out;
  ppmhp_data_t pin_oe;
  logic        ad_oe;
  logic        ack_out;
  logic        ack_oe;
  int          n_errors   = 0;
  int          num_checks = 0;
  logic        m_muxed;
  logic        m_ack;
  ppmhp_addr_t addrs [5] = '{9'h001, 9'h101, 9'h1FF, 9'h018, 9'h019};
  ppmhp_data_t vals  [5] = '{8'h5A, 8'hA5, 8'h3C, 8'hF0, 8'hC3};

  // Clock, 25 MHz
  always #20 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  ppmhp_port i_ppmhp_port (
    .mclk                     (mclk),
    .reset_n                  (reset_n),
    .por_n                    (por_n),
    .bus_style_select         (bus_sel),
    .sync_bus_select          (sync_sel),
    .clock_source_select      (clk_sel),
    .host                     (host),
    .ad_out                   (ad_out),
    .ad_oe                    (ad_oe),
    .transfer_ack_n_out       (ack_out),
    .transfer_ack_n_oe        (ack_oe),
    .programmable_io_pins_out (pin_out),
    .programmable_io_pins_oe  (pin_oe)
  );

  ppmhp_host_model i_ppmhp_host_model (
    .mclk   (mclk),
    .ad_out (ad_out),
    .ad_oe  (ad_oe),
    .ack_oe (ack_oe),
    .host   (host)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compare and count
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One access with its bus checks
  task automatic acc(input logic wr, input ppmhp_addr_t a,
                     input ppmhp_data_t d);
    ppmhp_data_t rd;
    logic        oe;
    logic        ack;
    logic        oe_off;
    i_ppmhp_host_model.access(m_muxed, wr, a, d, rd, oe, ack, oe_off);
    chk("ack", {7'h00, m_ack}, {7'h00, ack});
    chk("drive", {7'h00, ~wr}, {7'h00, oe});
    chk("float", 8'h00, {7'h00, oe_off});
    if (!wr) chk("rdata", d, rd);
  endtask

  // Reset into a strap mode, then defaults, writes and read-back
  task automatic run_mode(input logic bs, input logic sy,
                          input logic cs, input logic use_por);
    @(negedge mclk);
    {bus_sel, sync_sel, clk_sel} = {bs, sy, cs};
    m_muxed = bs;
    m_ack   = ~bs & sy & cs;
    if (use_por) por_n = 1'b0;
    else reset_n = 1'b0;
    repeat (8) @(negedge mclk);
    {reset_n, por_n} = 2'b11;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("pin_oe", 8'h00, pin_oe);
    chk("pin_out", 8'h00, pin_out);
    chk("ack_pin", 8'h00, {7'h00, ack_out});
    for (int i = 0; i < 5; i++) acc(1'b0, addrs[i], 8'h00);
    for (int i = 0; i < 5; i++) acc(1'b1, addrs[i], vals[i]);
    for (int i = 0; i < 5; i++) acc(1'b0, addrs[i], vals[i]);
    chk("pin_oe", vals[3], pin_oe);
    chk("pin_out", vals[4], pin_out);
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  // Sync separate, async muxed, sync strap with internal clock, sync muxed
  initial begin
    run_mode(1'b0, 1'b1, 1'b1, 1'b0);
    run_mode(1'b1, 1'b0, 1'b0, 1'b1);
    run_mode(1'b0, 1'b1, 1'b0, 1'b0);
    run_mode(1'b1, 1'b1, 1'b1, 1'b0);
    end_sim();
  end

  // Cuts a hang well past the run of about 465 cycles
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    $display("BAD watchdog expected done seen timeout");
    end_sim();
  end
endmodule // parallel_mpu_host_port_tb
